// ### rtl/adc_defs.svh
// Register indices, field positions, reset values and timing counts of the converter
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// Word indices; the byte address of each register is four times its index
`define IDX_POWER_CTL      10'h062
`define IDX_FREEZE_CTL     10'h063
`define IDX_START_CTL      10'h065
`define IDX_STATUS         10'h066
`define IDX_TEST           10'h068
`define IDX_PIN_INPUT      10'h06f
`define IDX_RESULT_BASE    10'h070
`define IDX_RESULT_LOW0    10'h071
`define IDX_RESULT_LOW1    10'h073
`define IDX_RESULT_LOW2    10'h075
`define IDX_RESULT_LOW3    10'h077
`define IDX_RESULT_LOW4    10'h079
`define IDX_RESULT_LOW5    10'h07b
`define IDX_RESULT_LOW6    10'h07d
`define IDX_RESULT_LOW7    10'h07f
`define RESULT_SLOT_MASK   10'h3f0

// Field positions
`define POWER_EN_BIT       7
`define FAST_CLEAR_BIT     6
`define HALT_WAIT_BIT      2
`define SCF_BIT            15
`define COUNT_LSB          8
`define SOFT_RST_BIT       15
`define TEST_SEL_LSB       11
`define TEST_MUX_BIT       10

// Reset values and SAR start values
`define FREEZE_RST         2'h0
`define START_RST          7'h00
`define SAR_MID            10'h200
`define SAR_TOP_BIT        4'h9

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Timing
`define CLK_MHZ            20
`define STOP_RECOVERY_NS   10000
`define STOP_RECOVERY_CYC  ((`STOP_RECOVERY_NS * `CLK_MHZ + 999) / 1000)
`define STEP_DIV           4

`endif

// ### rtl/adc_pkg.sv
// Types shared by the converter sequencer
package adc_pkg;

  // Sequencer states, Gray coded along idle -> convert and convert -> idle; recover -> idle flips both bits
  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_convert = 2'b01,
    st_recover = 2'b11
  } seq_state_e;

  // Freeze behaviour under debug halt
  typedef enum logic [1:0] {
    frz_continue = 2'b00,
    frz_reserved = 2'b01,
    frz_finish   = 2'b10,
    frz_at_once  = 2'b11
  } freeze_e;

  // Sequence start control word
  typedef struct packed {
    logic       eight_conversion_select;
    logic       scan;
    logic       multichannel_select;
    logic [3:0] channel_select;
  } seq_cfg_s;

endpackage : adc_pkg

// ### rtl/pin_sync.sv
// Two-stage synchronisers for the analogue pin levels and the comparator
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [8:0] async_in,
  output logic      [8:0] sync_out
);

  logic [8:0] meta_q;

  // One synchroniser per bit
  generate
    for (genvar i = 0; i < 9; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ### rtl/sar_engine.sv
// Ten-step successive-approximation register with test load
`timescale 1ns/1ps
`include "adc_defs.svh"
module sar_engine (
  input  wire logic       aclk,
  input  wire logic       srst,
  input  wire logic       abort,
  input  wire logic       start,
  input  wire logic       step_en,
  input  wire logic       comp_above,
  input  wire logic       load,
  input  wire logic [9:0] load_value,
  output logic      [9:0] approx_value,
  output logic            busy,
  output logic            done
);

  logic [3:0] bit_q;

  // Binary search, one bit per step enable, top bit first
  always_ff @(posedge aclk) begin
    if (srst) begin
      approx_value <= 10'h000;
      busy         <= 1'b0;
      done         <= 1'b0;
      bit_q        <= 4'h0;
    end else begin
      done <= 1'b0;
      if (load) begin
        approx_value <= load_value;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        approx_value <= `SAR_MID;
        bit_q        <= `SAR_TOP_BIT;
        busy         <= 1'b1;
      end else if (busy && step_en) begin
        if (!comp_above) begin
          approx_value[bit_q] <= 1'b0;
        end
        if (bit_q == 4'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          approx_value[bit_q - 4'h1] <= 1'b1;
          bit_q                      <= bit_q - 4'h1;
        end
      end
    end
  end

endmodule : sar_engine

// ### rtl/adc_sequencer.sv
// Converter sequencer, status flags, result store and AXI4-Lite register slave
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        special_mode,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        debug_halt_mode,
  input  wire logic [7:0]  pin_level_in,
  input  wire logic        comp_above,
  output logic      [3:0]  analog_mux_sel,
  output logic             sample_start,
  output logic      [9:0]  dac_value,
  output logic             converter_power_enable,
  output logic      [3:0]  factory_test_select,
  output logic             test_output_mux
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                  aw_full_q, w_full_q;
  logic [9:0]            widx_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_fire, rd_fire, wlo, whi;
  logic [9:0]            ridx;
  logic [31:0]           rd_d;
  logic [1:0]            rresp_d;
  logic                  ctl5_wr, stat_wr, test_wr, soft_rst_q, srst;
  logic                  stat_rd, res_rd;
  logic [2:0]            rslot;
  logic                  fast_flag_clear_q, halt_in_wait_q;
  logic [1:0]            freeze_q;
  adc_pkg::seq_cfg_s     cfg_q;
  adc_pkg::seq_state_e   state_q;
  logic [2:0]            conversion_counter_q;
  logic                  first_q, pend_q, stop_prev_q, launch, seq_end;
  logic [15:0]           rec_q;
  logic [1:0]            div_q;
  logic                  step_tick, halted, finish_freeze, conv_start, abort;
  logic [9:0]            sar_value;
  logic                  sar_busy, sar_done;
  logic                  sequence_done_flag_q;
  logic [7:0]            conversion_done_flags;
  logic [9:0]            results [8];
  logic [7:0]            pin_level_bits;
  logic                  comp_sync;

  // ----------------------------------------------------------------
  // Input synchronisers and SAR
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({comp_above, pin_level_in}),
    .sync_out ({comp_sync, pin_level_bits})
  );

  sar_engine u_sar (
    .aclk         (aclk),
    .srst         (srst),
    .abort        (abort),
    .start        (conv_start),
    .step_en      (step_tick),
    .comp_above   (comp_sync),
    .load         (test_wr && (wlo || whi)),
    .load_value   ({whi ? wdata_q[9:8] : sar_value[9:8], wlo ? wdata_q[7:0] : sar_value[7:0]}),
    .approx_value (sar_value),
    .busy         (sar_busy),
    .done         (sar_done)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign awready = !aw_full_q;
  assign wready  = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid;
  assign wlo     = wstrb_q[0];
  assign whi     = wstrb_q[1];

  // Address and data held until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      widx_q    <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        widx_q    <= awaddr[11:2];
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
    end
  end

  // Write response, error on an unmapped index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (mapped(widx_q)) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [9:0] idx);
    mapped = (idx == `IDX_POWER_CTL) || (idx == `IDX_FREEZE_CTL) ||
             (idx == `IDX_START_CTL) || (idx == `IDX_STATUS) ||
             (idx == `IDX_TEST) || (idx == `IDX_PIN_INPUT) ||
             ((idx & `RESULT_SLOT_MASK) == `IDX_RESULT_BASE);
  endfunction : mapped

  // Write strobes of individual registers
  assign ctl5_wr = wr_fire && (widx_q == `IDX_START_CTL) && wlo;
  assign stat_wr = wr_fire && (widx_q == `IDX_STATUS) && special_mode;
  assign test_wr = wr_fire && (widx_q == `IDX_TEST) && special_mode;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // power survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_power_enable <= 1'b0;
    end else if (wr_fire && (widx_q == `IDX_POWER_CTL) && wlo) begin
      converter_power_enable <= wdata_q[`POWER_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= test_wr && whi && wdata_q[`SOFT_RST_BIT];
    end
  end
  assign srst = !aresetn || soft_rst_q;

  // Mode, freeze, start and test fields
  always_ff @(posedge aclk) begin
    if (srst) begin
      fast_flag_clear_q   <= 1'b0;
      halt_in_wait_q      <= 1'b0;
      freeze_q            <= `FREEZE_RST;
      cfg_q               <= `START_RST;
      factory_test_select <= 4'h0;
      test_output_mux     <= 1'b0;
    end else begin
      if (wr_fire && (widx_q == `IDX_POWER_CTL) && wlo) begin
        fast_flag_clear_q <= wdata_q[`FAST_CLEAR_BIT];
        halt_in_wait_q    <= wdata_q[`HALT_WAIT_BIT];
      end
      if (wr_fire && (widx_q == `IDX_FREEZE_CTL) && wlo) begin
        freeze_q <= wdata_q[1:0];
      end
      if (ctl5_wr) begin
        cfg_q <= wdata_q[6:0];
      end
      if (test_wr && whi) begin
        factory_test_select <= wdata_q[`TEST_SEL_LSB +: 4];
        test_output_mux     <= wdata_q[`TEST_MUX_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Run gating and conversion timing
  // ----------------------------------------------------------------
  // halt causes
  assign halted = !converter_power_enable || stop_mode || (wait_mode && halt_in_wait_q) ||
                  (debug_halt_mode && (freeze_q == adc_pkg::frz_at_once));
  assign finish_freeze = debug_halt_mode && (freeze_q == adc_pkg::frz_finish);
  assign abort = ctl5_wr || !converter_power_enable || stop_mode;

  // Step enable divider, cleared to zero while halted
  always_ff @(posedge aclk) begin
    if (srst || halted) begin
      div_q <= 2'h0;
    end else begin
      div_q <= step_tick ? 2'h0 : div_q + 2'h1;
    end
  end
  assign step_tick = !halted && (div_q == 2'(`STEP_DIV - 1));

  assign conv_start = (state_q == adc_pkg::st_convert) && !sar_busy && !sar_done &&
                      !halted && !finish_freeze && !abort;
  assign launch     = pend_q && (state_q == adc_pkg::st_idle) && !abort && !stop_prev_q;
  assign seq_end    = sar_done && (state_q == adc_pkg::st_convert) &&
                      (conversion_counter_q == (cfg_q.eight_conversion_select ? 3'h7 : 3'h3));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Sequence state, stop recovery
  always_ff @(posedge aclk) begin
    if (srst) begin
      state_q     <= adc_pkg::st_idle;
      stop_prev_q <= 1'b0;
      rec_q       <= 16'h0000;
      first_q     <= 1'b0;
    end else begin
      stop_prev_q <= stop_mode;
      if (stop_mode) begin
        state_q <= adc_pkg::st_idle;
      end else if (stop_prev_q) begin
        state_q <= adc_pkg::st_recover;
        rec_q   <= 16'h0000;
      end else if (state_q == adc_pkg::st_recover) begin
        rec_q <= rec_q + 16'h0001;
        if (rec_q == 16'(`STOP_RECOVERY_CYC - 1)) begin
          state_q <= adc_pkg::st_idle;
        end
      end else if (abort) begin
        state_q <= adc_pkg::st_idle;
      end else if (launch) begin
        state_q <= adc_pkg::st_convert;
        first_q <= 1'b1;
      end else if (seq_end) begin
        first_q <= 1'b0;
        if (!cfg_q.scan) begin
          state_q <= adc_pkg::st_idle;
        end
      end
    end
  end

  // Pending start, held through stop recovery
  always_ff @(posedge aclk) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (!converter_power_enable) begin
      pend_q <= 1'b0;
    end else if (ctl5_wr) begin
      pend_q <= 1'b1;
    end else if (launch) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (srst) begin
      conversion_counter_q <= 3'h0;
    end else if (ctl5_wr || launch) begin
      conversion_counter_q <= 3'h0;
    end else if (seq_end) begin
      conversion_counter_q <= 3'h0;
    end else if (sar_done && (state_q == adc_pkg::st_convert)) begin
      conversion_counter_q <= conversion_counter_q + 3'h1;
    end
  end

  // Channel for the front end, registered
  always_ff @(posedge aclk) begin
    if (srst) begin
      analog_mux_sel <= 4'h0;
      sample_start   <= 1'b0;
    end else begin
      sample_start <= conv_start;
      if (!cfg_q.multichannel_select) begin
        analog_mux_sel <= cfg_q.channel_select;
      end else if (cfg_q.eight_conversion_select) begin
        analog_mux_sel <= {cfg_q.channel_select[3], conversion_counter_q};
      end else begin
        analog_mux_sel <= {cfg_q.channel_select[3:2], conversion_counter_q[1:0]};
      end
    end
  end
  assign dac_value = sar_value;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign stat_rd = rd_fire && (ridx == `IDX_STATUS);
  assign res_rd  = rd_fire && ((ridx & `RESULT_SLOT_MASK) == `IDX_RESULT_BASE);
  assign rslot   = ridx[3:1];

  // Sequence-done flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (srst) begin
      sequence_done_flag_q <= 1'b0;
    end else begin
      if (ctl5_wr && (!fast_flag_clear_q || (state_q == adc_pkg::st_convert))) begin
        sequence_done_flag_q <= 1'b0;
      end
      if (fast_flag_clear_q && res_rd && (rslot == 3'h0)) begin
        sequence_done_flag_q <= 1'b0;
      end
      if (stat_wr && whi) begin
        sequence_done_flag_q <= wdata_q[`SCF_BIT];
      end
      if (seq_end && first_q) begin
        sequence_done_flag_q <= 1'b1;
      end
    end
  end

  // Per-slot result and conversion-done flag
  generate
    for (genvar s = 0; s < 8; s++) begin : g_slot
      logic       done_q, armed_q;
      logic [9:0] res_q;
      logic       hit;
      assign hit                      = sar_done && (state_q == adc_pkg::st_convert) &&
                                        (conversion_counter_q == 3'(s));
      assign conversion_done_flags[s] = done_q;
      assign results[s]               = res_q;

      always_ff @(posedge aclk) begin
        if (hit) begin
          res_q <= sar_value;
        end
      end

      always_ff @(posedge aclk) begin
        if (srst) begin
          done_q  <= 1'b0;
          armed_q <= 1'b0;
        end else begin
          if (ctl5_wr && (state_q == adc_pkg::st_convert)) begin
            done_q  <= 1'b0;
            armed_q <= 1'b0;
          end
          if (stat_rd) begin
            armed_q <= done_q;
          end
          if (res_rd && (rslot == 3'(s)) && (fast_flag_clear_q || armed_q)) begin
            done_q  <= 1'b0;
            armed_q <= 1'b0;
          end
          if (stat_wr && wlo) begin
            done_q <= wdata_q[s];
          end
          if (hit) begin
            done_q <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  assign ridx    = araddr[11:2];

  // Read data for the addressed register
  always_comb begin
    rd_d    = 32'h0000_0000;
    rresp_d = `RESP_OKAY;
    case (ridx)
      `IDX_POWER_CTL: begin
        rd_d[`POWER_EN_BIT]   = converter_power_enable;
        rd_d[`FAST_CLEAR_BIT] = fast_flag_clear_q;
        rd_d[`HALT_WAIT_BIT]  = halt_in_wait_q;
      end
      `IDX_FREEZE_CTL: rd_d[1:0] = freeze_q;
      `IDX_START_CTL:  rd_d[6:0] = cfg_q;
      `IDX_STATUS: begin
        rd_d[`SCF_BIT]        = sequence_done_flag_q;
        rd_d[`COUNT_LSB +: 3] = conversion_counter_q;
        rd_d[7:0]             = conversion_done_flags;
      end
      `IDX_TEST: begin
        if (special_mode) begin
          rd_d[9:0]                = sar_value;
          rd_d[`TEST_MUX_BIT]      = test_output_mux;
          rd_d[`TEST_SEL_LSB +: 4] = factory_test_select;
        end
      end
      `IDX_PIN_INPUT: rd_d[7:0] = pin_level_bits;
      default: begin
        if ((ridx & `RESULT_SLOT_MASK) == `IDX_RESULT_BASE) begin
          rd_d[7:0] = ridx[0] ? {results[rslot][1:0], 6'h00} : results[rslot][9:2];
        end else begin
          rresp_d = `RESP_SLVERR;
        end
      end
    endcase
  end

  // Read answer held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_d;
      rresp  <= rresp_d;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : adc_sequencer

// ### testbench/adc_seq_checker.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_seq_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [11:0] araddr,
  input wire logic        arvalid,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        special_mode,
  input wire logic        stop_mode,
  input wire logic [7:0]  pin_level_in,
  input wire logic        sample_start,
  input wire logic        converter_power_enable,
  input wire logic [3:0]  factory_test_select,
  input wire logic [3:0]  analog_mux_sel
);
  logic [7:0] rec_q;
  logic       rd_go;
  logic       tst_go;
  logic       st_go;
  logic [6:0] cfg_q;
  // Start control word as last taken
  assign st_go = awvalid && awready && wvalid && wready && wstrb[0]
                 && awaddr[11:2] == `IDX_START_CTL;
  always_ff @(posedge aclk) begin
    if (!aresetn) cfg_q <= 7'h00;
    else if (st_go) cfg_q <= wdata[6:0];
  end
  // Read taken; test write taken in special mode
  assign rd_go  = arvalid && !rvalid;
  assign tst_go = awvalid && awready && wvalid && wready && special_mode && wstrb[1]
                  && awaddr[11:2] == `IDX_TEST;
  // Cycles since stop mode ended, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) rec_q <= 8'hff;
    else if (stop_mode) rec_q <= 8'h00;
    else if (rec_q != 8'hff) rec_q <= rec_q + 8'h01;
  end
  // ----------------
  // Assertions
  // ----------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hide_test_a: assert property (rd_go && araddr[11:2] == `IDX_TEST && !special_mode
    |=> rdata == 32'h0) else $error("test reg visible");
  pin_read_a: assert property (rd_go && araddr[11:2] == `IDX_PIN_INPUT
    && $stable(pin_level_in) && pin_level_in == $past(pin_level_in, 2)
    |=> rdata[7:0] == $past(pin_level_in)) else $error("bad pin read");
  status_ok_a: assert property (rd_go && (araddr[11:2] == `IDX_STATUS
    || araddr[11:6] == 6'h07) |=> rresp == `RESP_OKAY) else $error("bad read resp");
  power_off_a: assert property (!converter_power_enable [*2] |-> !sample_start)
    else $error("sample while off");
  stop_idle_a: assert property (stop_mode [*2] |-> !sample_start)
    else $error("sample in stop");
  stop_wait_a: assert property (sample_start |-> rec_q >= `STOP_RECOVERY_CYC)
    else $error("sample in recovery");
  soft_reset_a: assert property (tst_go && wdata[15] |-> ##3 factory_test_select == 4'h0
    && converter_power_enable == $past(converter_power_enable, 3)) else $error("bad soft reset");
  test_sel_a: assert property (tst_go && !wdata[15]
    |-> ##2 factory_test_select == $past(wdata[14:11], 2)) else $error("bad test select");
  single_mux_a: assert property (sample_start && !cfg_q[4]
    |-> analog_mux_sel == cfg_q[3:0]) else $error("bad single channel");
  group_mux_a: assert property (sample_start && cfg_q[4]
    |-> analog_mux_sel[3] == cfg_q[3] && (cfg_q[6] || analog_mux_sel[2] == cfg_q[2]))
    else $error("bad channel group");
endmodule : adc_seq_checker

// ### testbench/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "adc_defs.svh"
module testbench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, rvalid, special_mode, stop_mode, wait_mode, comp_above, debug_halt_mode;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  pin_level_in, p;
  logic [7:0]  lfsr_q = 8'h0b;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [33:0] exp_q[$], msk_q[$];
  int          err_count, n_compared;
  adc_sequencer dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready(), .rdata, .rresp, .rvalid,
    .rready, .special_mode, .stop_mode, .wait_mode, .debug_halt_mode, .pin_level_in,
    .comp_above, .analog_mux_sel(), .sample_start(), .dac_value(), .converter_power_enable(),
    .factory_test_select(), .test_output_mux());
  // Bus clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    exp_q.push_back(34'h0);
    msk_q.push_back(34'h3_0000_0000);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {idx, 2'b00, 16'h0, d, 4'h3};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(a && w)) begin
      @(posedge aclk);
      a = a | awready;
      w = w | wready;
      awvalid <= !a;
      wvalid <= !w;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {idx, 2'b00, 2'b11};
    do @(posedge aclk); while (rvalid !== 1'b0);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // Response monitor takes the oldest note
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) chk({bresp, 32'h0} & msk_q.pop_front(), exp_q.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata} & msk_q.pop_front(), exp_q.pop_front());
  end
  // Random comparator answers
  always @(posedge aclk) begin
    lfsr_q = lfsr(lfsr_q);
    comp_above <= lfsr_q[0];
  end
  // Watchdog
  initial begin
    idle(20000);
    err_count++;
    give_verdict();
  end
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, special_mode, stop_mode} = '0;
    {wait_mode, debug_halt_mode, awaddr, araddr, wdata, wstrb, pin_level_in} = '0;
    idle(10);
    aresetn <= 1'b1;
    wr(`IDX_TEST, 16'h5555);
    rd(`IDX_TEST, 34'h0, '1);
    rd(10'h000, {`RESP_SLVERR, 32'h0}, '1);
    for (int i = 0; i < 3; i++) begin
      @(negedge aclk);
      p = lfsr_q;
      @(posedge aclk);
      pin_level_in <= p;
      idle(4);
      rd(`IDX_PIN_INPUT, {26'h0, p}, '1);
    end
    $display("register test done");
    special_mode <= 1'b1;
    wr(`IDX_POWER_CTL, 16'h0080);
    rd(`IDX_TEST, 34'h0, '1);
    wr(`IDX_TEST, 16'h5555);
    rd(`IDX_TEST, 34'h5555, '1);
    wr(`IDX_TEST, 16'h8000);
    rd(`IDX_POWER_CTL, 34'h80, 34'h80);
    special_mode <= 1'b0;
    $display("test register done");
    wr(`IDX_START_CTL, 16'h0003);
    idle(400);
    rd(`IDX_STATUS, 34'h800f, 34'h87ff);
    rd(`IDX_RESULT_LOW0, 34'h0, 34'h3_0000_003f);
    rd(`IDX_STATUS, 34'h800e, 34'h80ff);
    wr(`IDX_START_CTL, 16'h0050);
    rd(`IDX_STATUS, 34'h000e, 34'h87ff);
    idle(700);
    rd(`IDX_STATUS, 34'h80ff, 34'h87ff);
    wr(`IDX_POWER_CTL, 16'h00c0);
    wr(`IDX_START_CTL, 16'h0003);
    idle(400);
    rd(`IDX_RESULT_LOW0, 34'h0, 34'h3_0000_0000);
    rd(`IDX_STATUS, 34'h00fe, 34'h87ff);
    wr(`IDX_FREEZE_CTL, 16'h0003);
    debug_halt_mode <= 1'b1;
    wr(`IDX_START_CTL, 16'h003c);
    idle(300);
    rd(`IDX_STATUS, 34'h0, 34'h8000);
    debug_halt_mode <= 1'b0;
    idle(400);
    rd(`IDX_STATUS, 34'h8000, 34'h8000);
    $display("sequence test done");
    wr(`IDX_POWER_CTL, 16'h0000);
    wr(`IDX_START_CTL, 16'h0003);
    idle(400);
    rd(`IDX_STATUS, 34'h0, 34'h8000);
    wr(`IDX_POWER_CTL, 16'h0084);
    wait_mode <= 1'b1;
    wr(`IDX_START_CTL, 16'h0003);
    idle(400);
    rd(`IDX_STATUS, 34'h0, 34'h8000);
    wait_mode <= 1'b0;
    wr(`IDX_POWER_CTL, 16'h0080);
    wr(`IDX_START_CTL, 16'h0003);
    idle(20);
    stop_mode <= 1'b1;
    idle(5);
    stop_mode <= 1'b0;
    wr(`IDX_START_CTL, 16'h0003);
    idle(300);
    rd(`IDX_STATUS, 34'h0, 34'h8000);
    idle(200);
    rd(`IDX_STATUS, 34'h8000, 34'h8000);
    $display("mode test done");
    give_verdict();
  end
endmodule : testbench
bind adc_sequencer adc_seq_checker chk_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
  .wstrb, .wvalid, .wready, .araddr, .arvalid, .rvalid, .rdata, .rresp, .special_mode,
  .stop_mode, .pin_level_in, .sample_start, .converter_power_enable, .factory_test_select,
  .analog_mux_sel);
